// *** core/jrdu_map.svh ***
// register offsets, field positions and reset values of the debug unit
// assumes 32-bit apb words at byte offsets, jtag data register of 41 bits
`ifndef JRDU_MAP_SVH
`define JRDU_MAP_SVH
`define JRDU_A_CTRL 8'h00
`define JRDU_A_STAT 8'h04
`define JRDU_A_IRQ  8'h08
`define JRDU_A_MASK 8'h0c
`define JRDU_A_MCMD 8'h10
`define JRDU_A_MRD  8'h14
`define JRDU_A_CMB  8'h18
`define JRDU_A_RLO  8'h1c
`define JRDU_A_RHI  8'h20
`define JRDU_A_BP0  8'h24
`define JRDU_A_LAST 8'h30
`define JRDU_C_HALT 0
`define JRDU_C_RUN  1
`define JRDU_C_RST  2
`define JRDU_C_STEP 3
`define JRDU_C_CFG  4
`define JRDU_CFG_RST 4'h0
`define JRDU_MASK_RST 3'h0
`define JRDU_SP_ANY 3'h7
`define JRDU_IR_DBG 4'h8
`define JRDU_IR_TRC 4'h9
`define JRDU_IR_BYP 4'hf
`define JRDU_IR_CAP 4'h1
`define JRDU_DRW 41
`endif

// *** core/jrdu_pkg.sv ***
// types shared by the debug unit modules
// assumes the map header sits beside it
`include "jrdu_map.svh"
package jrdu_pkg;
    typedef enum {CS_RUN, CS_HALT, CS_STEP} jrdu_core_t;
    typedef enum {TS_RESET, TS_IDLE, TS_SDR, TS_CDR, TS_SHDR, TS_E1DR, TS_PDR, TS_E2DR,
                  TS_UDR, TS_SIR, TS_CIR, TS_SHIR, TS_E1IR, TS_PIR, TS_E2IR, TS_UIR} jrdu_tap_t;
    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [2:0]  space;
        logic [15:0] addr;
        logic [7:0]  data;
    } jrdu_acc_t;
    typedef struct packed {
        logic        en;
        logic        q_wr;
        logic        q_rd;
        logic [2:0]  space;
        logic [7:0]  data;
        logic [15:0] addr;
    } jrdu_bp_t;
    function automatic logic jrdu_qual(input jrdu_bp_t c, input jrdu_acc_t a);
        return a.valid && c.en && (a.wr ? c.q_wr : c.q_rd)
            && (c.space == `JRDU_SP_ANY || c.space == a.space);
    endfunction
endpackage

// *** core/jrdu_bpcmp.sv ***
// one breakpoint comparator, registered hit
// assumes the core access bus is on the same clock
`timescale 1ns/1ps
`default_nettype none
module jrdu_bpcmp import jrdu_pkg::*; #(
    parameter bit USE_DATA = 1'b0
) (
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire jrdu_bp_t  cfg,
    input  wire jrdu_acc_t acc,
    output logic           hit
);
    wire match;
    // RULE7 direction and space qualification
    assign match = jrdu_qual(cfg, acc) && acc.addr == cfg.addr
                && (!USE_DATA || acc.data == cfg.data);
    always_ff @(posedge clk) begin
        hit <= rst_n ? match : 1'b0;
    end
    a_bp_disabled: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        !cfg.en |=> !hit) else $error("disabled breakpoint hit");
endmodule
`default_nettype wire

// *** core/jrdu_tap.sv ***
// jtag tap controller run on the core clock from sampled tck edges
// assumes tck_r/tck_f are one-cycle edge pulses, tms/tdi synchronised
`timescale 1ns/1ps
`default_nettype none
`include "jrdu_map.svh"
module jrdu_tap import jrdu_pkg::*; #(
    parameter int W = `JRDU_DRW
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         tck_r,
    input  wire logic         tck_f,
    input  wire logic         tms,
    input  wire logic         tdi,
    input  wire logic [W-1:0] cap,
    output logic [3:0]        ir,
    output logic [W-1:0]      dr,
    output logic              cap_dr,
    output logic              upd_dr,
    output logic              sh_ir,
    output logic              tdo
);
    jrdu_tap_t st_q, st_d;
    logic [3:0] ir_sh_q;
    always_comb begin
        case (st_q)
            TS_RESET: st_d = tms ? TS_RESET : TS_IDLE;
            TS_IDLE:  st_d = tms ? TS_SDR : TS_IDLE;
            TS_SDR:   st_d = tms ? TS_SIR : TS_CDR;
            TS_CDR:   st_d = tms ? TS_E1DR : TS_SHDR;
            TS_SHDR:  st_d = tms ? TS_E1DR : TS_SHDR;
            TS_E1DR:  st_d = tms ? TS_UDR : TS_PDR;
            TS_PDR:   st_d = tms ? TS_E2DR : TS_PDR;
            TS_E2DR:  st_d = tms ? TS_UDR : TS_SHDR;
            TS_UDR:   st_d = tms ? TS_SDR : TS_IDLE;
            TS_SIR:   st_d = tms ? TS_RESET : TS_CIR;
            TS_CIR:   st_d = tms ? TS_E1IR : TS_SHIR;
            TS_SHIR:  st_d = tms ? TS_E1IR : TS_SHIR;
            TS_E1IR:  st_d = tms ? TS_UIR : TS_PIR;
            TS_PIR:   st_d = tms ? TS_E2IR : TS_PIR;
            TS_E2IR:  st_d = tms ? TS_UIR : TS_SHIR;
            TS_UIR:   st_d = tms ? TS_SDR : TS_IDLE;
            default:  st_d = TS_RESET;
        endcase
    end
    assign cap_dr = tck_r && st_q == TS_CDR;
    assign upd_dr = tck_f && st_q == TS_UDR;
    assign sh_ir  = st_q == TS_SHIR;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q    <= TS_RESET;
            ir      <= `JRDU_IR_BYP;
            ir_sh_q <= `JRDU_IR_CAP;
            dr      <= '0;
            tdo     <= 1'b0;
        end else begin
            if (tck_r) begin
                st_q <= st_d;
                if (st_q == TS_CDR) dr <= cap;
                if (st_q == TS_SHDR) dr <= {tdi, dr[W-1:1]};
                if (st_q == TS_CIR) ir_sh_q <= `JRDU_IR_CAP;
                if (st_q == TS_SHIR) ir_sh_q <= {tdi, ir_sh_q[3:1]};
            end
            if (tck_f) begin
                tdo <= st_q == TS_SHDR ? dr[0] : (sh_ir ? ir_sh_q[0] : 1'b0);
                if (st_q == TS_UIR) ir <= ir_sh_q;
                if (st_q == TS_RESET) ir <= `JRDU_IR_BYP;
            end
        end
    end
endmodule
`default_nettype wire

// *** core/jrdu_top.sv ***
// run-time debug unit: jtag access, core run control, breakpoints, trace
// assumes a core that advances only while CORE_RUN is high and pulses
// INSTR_DONE per finished instruction; APB on MCLK; jtag pins asynchronous
// Functional notes
// RULE1 - debug shares the jtag port with in-system programming by instruction select
// RULE2 - host can halt, run, reset and single-step the core
// RULE3 - three comparators match on address only
// RULE4 - one range breakpoint fires inside or, selectably, outside the range
// RULE5 - fourth comparator matches address and data together
// RULE6 - fourth comparator combines by AND or OR with one other comparator
// RULE7 - breakpoints qualify by read/write and by memory space
// RULE8 - a break halts the core, pulses the event pin, or both
// RULE9 - host reads and writes registers and all memory spaces
// RULE10 - debug memory accesses steal bus cycles, core keeps running
// RULE11 - trace is not stored, it is shifted out over jtag
// RULE12 - tracing throttles the core to the trace bandwidth
// RULE13 - event pin as output pulses on each break
// RULE14 - output pulse is active low and one clock long
// RULE15 - event pin as input breaks on a falling edge
// RULE16 - a halt stops only the core, peripheral clocks run on
// RULE17 - host should disable the watchdog before debugging
// RULE18 - single step runs exactly one instruction then halts again
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "jrdu_map.svh"
module jrdu_top import jrdu_pkg::*; (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        TCK,
    input  wire logic        TMS,
    input  wire logic        TDI,
    output logic             TDO,
    output logic             ISP_SEL,
    input  wire logic        ISP_TDO,
    input  wire logic        EVT_IN,
    output logic             EVT_OUT_N,
    output logic             EVT_OE,
    output logic             CORE_RUN,
    output logic             CORE_RST,
    input  wire logic        INSTR_DONE,
    input  wire logic [15:0] PC,
    input  wire jrdu_acc_t   ACC,
    output logic             DBG_REQ,
    output jrdu_acc_t        DBG,
    input  wire logic        DBG_ACK,
    input  wire logic [7:0]  DBG_RDATA,
    output logic             IRQ
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic [2:0] evt_s;
    always_ff @(posedge MCLK) begin
        tck_s <= RST_N ? {tck_s[1:0], TCK} : 3'h7;
        tms_s <= RST_N ? {tms_s[0], TMS} : 2'h3;
        tdi_s <= RST_N ? {tdi_s[0], TDI} : 2'h0;
        evt_s <= RST_N ? {evt_s[1:0], EVT_IN} : 3'h7;
    end
    wire tck_r    = tck_s[1] & ~tck_s[2];
    wire tck_f    = ~tck_s[1] & tck_s[2];
    wire evt_fall = ~evt_s[1] & evt_s[2];

    ////////////////////////////////////////////////////////////////////////
    // state
    jrdu_core_t  st_q, st_d;
    logic [3:0]  cfg_q;
    logic [2:0]  mask_q;
    logic [2:0]  stat_q;
    logic [3:0]  cmb_q;
    logic [30:0] rlo_q;
    logic [15:0] rhi_q;
    logic [29:0] bp_q [0:3];
    logic        busy_q;
    logic [7:0]  mrd_q;
    logic        trc_full_q;
    logic [15:0] trc_pc_q;
    logic        rng_q;
    logic        brk_prev_q;
    logic        jt_pend_q;
    logic        jt_wr_q;
    logic [7:0]  jt_adr_q;
    logic [31:0] jt_dat_q;
    logic [31:0] jt_rdat_q;
    wire         trace_en  = cfg_q[0];
    wire         evt_dir   = cfg_q[1];
    wire         brk_halt  = cfg_q[2];
    wire         brk_evt   = cfg_q[3];

    function automatic logic [31:0] rdw(input logic [7:0] a);
        case (a)
            `JRDU_A_CTRL: rdw = {24'h0, cfg_q, 4'h0};
            `JRDU_A_STAT: rdw = {27'h0, trace_en & trc_full_q, trc_full_q, busy_q,
                                 st_q == CS_STEP, st_q == CS_HALT};
            `JRDU_A_IRQ:  rdw = {29'h0, stat_q};
            `JRDU_A_MASK: rdw = {29'h0, mask_q};
            `JRDU_A_MCMD: rdw = {DBG.wr, 4'h0, DBG.space, DBG.data, DBG.addr};
            `JRDU_A_MRD:  rdw = {24'h0, mrd_q};
            `JRDU_A_CMB:  rdw = {28'h0, cmb_q};
            `JRDU_A_RLO:  rdw = {1'b0, rlo_q};
            `JRDU_A_RHI:  rdw = {16'h0, rhi_q};
            8'h24:        rdw = {2'h0, bp_q[0]};
            8'h28:        rdw = {2'h0, bp_q[1]};
            8'h2c:        rdw = {2'h0, bp_q[2]};
            8'h30:        rdw = {2'h0, bp_q[3]};
            default:      rdw = 32'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // jtag tap and port sharing
    wire [3:0]           ir;
    wire [`JRDU_DRW-1:0] dr;
    wire                 cap_dr;
    wire                 upd_dr;
    wire                 sh_ir;
    wire                 tap_tdo;
    wire                 ir_dbg = ir == `JRDU_IR_DBG;
    wire                 ir_trc = ir == `JRDU_IR_TRC;
    // RULE1 other instruction codes hand the port to programming
    wire                 isp    = ~(ir_dbg | ir_trc | ir == `JRDU_IR_BYP);
    // RULE11 trace word is captured straight into the scan chain
    wire [`JRDU_DRW-1:0] cap    = ir_trc ? {24'h0, trc_full_q, trc_pc_q}
                                         : {1'b0, jt_adr_q, jt_rdat_q};
    jrdu_tap #(.W(`JRDU_DRW)) u_tap (
        .clk    (MCLK),
        .rst_n  (RST_N),
        .tck_r  (tck_r),
        .tck_f  (tck_f),
        .tms    (tms_s[1]),
        .tdi    (tdi_s[1]),
        .cap    (cap),
        .ir     (ir),
        .dr     (dr),
        .cap_dr (cap_dr),
        .upd_dr (upd_dr),
        .sh_ir  (sh_ir),
        .tdo    (tap_tdo)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state
    wire apb_acc = PSEL & PENABLE & ~PREADY;
    wire apb_go  = PSEL & PENABLE & PREADY;
    wire apb_bad = PADDR[1:0] != 2'h0 || PADDR > `JRDU_A_LAST;
    wire w_apb   = apb_go & PWRITE & ~PSLVERR;
    wire jt_go   = jt_pend_q & ~apb_go;
    wire w_en    = w_apb | (jt_go & jt_wr_q);
    wire [7:0]  w_a = w_apb ? PADDR : jt_adr_q;
    wire [31:0] w_d = w_apb ? PWDATA : jt_dat_q;
    wire wr_ctrl = w_en && w_a == `JRDU_A_CTRL;
    wire wr_mcmd = w_en && w_a == `JRDU_A_MCMD;
    // RULE2 command bits act once per write
    wire halt_c  = wr_ctrl & w_d[`JRDU_C_HALT];
    wire run_c   = wr_ctrl & w_d[`JRDU_C_RUN];
    wire rst_c   = wr_ctrl & w_d[`JRDU_C_RST];
    wire step_c  = wr_ctrl & w_d[`JRDU_C_STEP];
    wire rd_irq  = apb_go & ~PWRITE & PADDR == `JRDU_A_IRQ;
    always_ff @(posedge MCLK) begin
        PREADY  <= RST_N & apb_acc;
        PSLVERR <= RST_N & apb_acc & apb_bad;
        PRDATA  <= (RST_N & apb_acc & ~PWRITE & ~apb_bad) ? rdw(PADDR) : 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // jtag register access, deferred one cycle on an apb collision
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            jt_pend_q <= 1'b0;
            jt_wr_q   <= 1'b0;
            jt_adr_q  <= 8'h00;
            jt_dat_q  <= 32'h0;
            jt_rdat_q <= 32'h0;
        end else if (upd_dr & ir_dbg) begin
            jt_pend_q <= 1'b1;
            {jt_wr_q, jt_adr_q, jt_dat_q} <= dr;
        end else if (jt_go) begin
            jt_pend_q <= 1'b0;
            // RULE9 host reads any register over jtag
            if (!jt_wr_q) jt_rdat_q <= rdw(jt_adr_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            cfg_q  <= `JRDU_CFG_RST;
            mask_q <= `JRDU_MASK_RST;
            cmb_q  <= 4'h0;
            rlo_q  <= 31'h0;
            rhi_q  <= 16'h0;
        end else if (w_en) begin
            if (w_a == `JRDU_A_CTRL) cfg_q <= w_d[`JRDU_C_CFG+3:`JRDU_C_CFG];
            if (w_a == `JRDU_A_MASK) mask_q <= w_d[2:0];
            if (w_a == `JRDU_A_CMB) cmb_q <= w_d[3:0];
            if (w_a == `JRDU_A_RLO) rlo_q <= w_d[30:0];
            if (w_a == `JRDU_A_RHI) rhi_q <= w_d[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // breakpoints
    wire [3:0] hit;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_bp
            always_ff @(posedge MCLK) begin
                if (!RST_N) bp_q[gi] <= 30'h0;
                else if (w_en && w_a == `JRDU_A_BP0 + 8'(4 * gi)) bp_q[gi] <= w_d[29:0];
            end
            // RULE3 address compare on the first three
            // RULE5 the fourth also compares data
            jrdu_bpcmp #(.USE_DATA(gi == 3)) u_bp (
                .clk   (MCLK),
                .rst_n (RST_N),
                .cfg   (jrdu_bp_t'(bp_q[gi])),
                .acc   (ACC),
                .hit   (hit[gi])
            );
        end
    endgenerate
    wire jrdu_bp_t rcfg = jrdu_bp_t'(rlo_q[29:0]);
    wire in_rng  = ACC.addr >= rcfg.addr && ACC.addr <= rhi_q;
    always_ff @(posedge MCLK) begin
        // RULE4 inside, or outside when selected
        rng_q <= RST_N & jrdu_qual(rcfg, ACC) & (in_rng ^ rlo_q[30]);
    end
    // RULE6 fourth comparator joined with one partner by and/or
    wire [1:0] psel   = cmb_q[2:1];
    wire       cmb_en = cmb_q[3];
    wire       part   = hit[psel];
    wire       comb   = cmb_q[0] ? hit[3] & part : hit[3] | part;
    wire [3:0] solo   = hit & ~(cmb_en ? (4'h8 | (4'h1 << psel)) : 4'h0);
    // RULE15 falling edge on the event input breaks
    wire       ext_ev = evt_fall & ~evt_dir;
    wire       brk_c  = |solo | (cmb_en & comb) | rng_q | ext_ev;
    wire       brk_p  = brk_c & ~brk_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // run control
    always_comb begin
        st_d = st_q;
        case (st_q)
            // RULE8 break may halt
            CS_RUN:  if (halt_c | (brk_p & brk_halt)) st_d = CS_HALT;
            CS_HALT: if (run_c) st_d = CS_RUN;
                     else if (step_c) st_d = CS_STEP;
            // RULE18 back to halt after one instruction
            CS_STEP: if (INSTR_DONE | halt_c) st_d = CS_HALT;
            default: st_d = CS_HALT;
        endcase
    end
    wire trc_ld  = INSTR_DONE & trace_en & ~trc_full_q;
    wire trc_clr = cap_dr & ir_trc;
    wire trc_d   = trc_ld | (trc_full_q & ~trc_clr);
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            st_q       <= CS_RUN;
            trc_full_q <= 1'b0;
            trc_pc_q   <= 16'h0;
            CORE_RUN   <= 1'b0;
            CORE_RST   <= 1'b0;
        end else begin
            st_q       <= st_d;
            trc_full_q <= trc_d;
            if (trc_ld) trc_pc_q <= PC;
            // RULE16 only the core advance is gated
            // RULE12 unread trace word stalls the core
            CORE_RUN   <= st_d != CS_HALT && !(trace_en && trc_d);
            CORE_RST   <= rst_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle-stolen memory access
    wire mem_go   = wr_mcmd & ~busy_q;
    wire mem_done = DBG_REQ & DBG_ACK;
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            busy_q  <= 1'b0;
            DBG_REQ <= 1'b0;
            DBG     <= '0;
            mrd_q   <= 8'h00;
        end else if (mem_go) begin
            // RULE10 request the bus, the core keeps its run state
            busy_q  <= 1'b1;
            DBG_REQ <= 1'b1;
            DBG     <= {1'b1, w_d[31], w_d[26:24], w_d[15:0], w_d[23:16]};
        end else if (mem_done) begin
            busy_q  <= 1'b0;
            DBG_REQ <= 1'b0;
            if (!DBG.wr) mrd_q <= DBG_RDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event pin, interrupt, tdo
    wire [2:0] ev    = {ext_ev, mem_done, brk_p};
    wire [2:0] clr   = rd_irq ? PRDATA[2:0] : 3'h0;
    wire [2:0] stat_d = (stat_q & ~clr) | ev;
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            stat_q     <= 3'h0;
            IRQ        <= 1'b0;
            brk_prev_q <= 1'b0;
            EVT_OUT_N  <= 1'b1;
            EVT_OE     <= 1'b0;
            ISP_SEL    <= 1'b0;
            TDO        <= 1'b0;
        end else begin
            stat_q     <= stat_d;
            IRQ        <= |(stat_d & mask_q);
            brk_prev_q <= brk_c;
            // RULE13 pulse on each break
            // RULE14 low for one clock
            EVT_OUT_N  <= ~(brk_p & brk_evt & evt_dir);
            EVT_OE     <= evt_dir;
            ISP_SEL    <= isp;
            TDO        <= (isp & ~sh_ir) ? ISP_TDO : tap_tdo;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_evt_one_clk: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE14
        $fell(EVT_OUT_N) |=> EVT_OUT_N) else $error("event pulse longer than a clock");
    a_evt_on_brk: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE13
        brk_p && brk_evt && evt_dir |=> !EVT_OUT_N && EVT_OE) else $error("no event pulse");
    a_brk_halt: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE8
        st_q == CS_RUN && brk_p && brk_halt |=> st_q == CS_HALT ##1 !CORE_RUN)
        else $error("break did not halt");
    a_step_once: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE18
        st_q == CS_STEP && INSTR_DONE |=> st_q == CS_HALT && !CORE_RUN)
        else $error("step did not stop");
    a_halt_stops: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE2
        st_q == CS_HALT |-> !CORE_RUN) else $error("core runs while halted");
    a_trace_stall: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE12
        trace_en && trc_full_q |-> !CORE_RUN) else $error("trace not throttling");
    a_ext_break: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE15
        $fell(evt_s[1]) && !evt_dir |=> stat_q[2]) else $error("event input missed");
    a_mem_steal: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE10
        mem_go && st_q == CS_RUN && !halt_c && !brk_p |=> DBG_REQ && st_q == CS_RUN)
        else $error("memory access disturbed core");
    a_mem_done: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE9
        mem_done |=> !busy_q && stat_q[1]) else $error("memory access not finished");
    a_range_out: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE4
        jrdu_qual(rcfg, ACC) && !in_rng && rlo_q[30] |=> rng_q)
        else $error("outside range missed");
endmodule
`default_nettype wire

// *** tb/jrdu_probe.sv ***
// jtag probe model: tck runs only inside scans and tap resets, 800 ns period
// assumes tasks are entered at a rising mclk edge
`timescale 1ns/1ps
`default_nettype none
module jrdu_probe (
    input  wire logic MCLK,
    input  wire logic TDO,
    output logic      TCK,
    output logic      TMS,
    output logic      TDI
);
    initial begin
        TCK = 1'b1;
        TMS = 1'b1;
        TDI = 1'b1;
    end
    // one tck period, tdo taken at end of high phase
    task automatic tb(input logic m, input logic d, output logic o);
        TCK <= 1'b0;
        TMS <= m;
        TDI <= d;
        repeat (4) @(posedge MCLK);
        TCK <= 1'b1;
        repeat (4) @(posedge MCLK);
        o = TDO;
    endtask
    task automatic tap_reset();
        logic o;
        for (int i = 0; i < 6; i++) tb(i < 5, 1'b0, o);
    endtask
    task automatic scan(input logic ir, input int n, input logic [40:0] din,
                        output logic [40:0] dout);
        logic o;
        dout = '0;
        tb(1'b1, 1'b0, o);
        if (ir) tb(1'b1, 1'b0, o);
        tb(1'b0, 1'b0, o);
        tb(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            tb(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tb(1'b1, ~din[n-1], o);
        tb(1'b0, din[n-1], o);
    endtask
endmodule
`default_nettype wire

// *** tb/jtag_run_time_debug_unit_tb_top.sv ***
// bench: apb master, core bus model, event pin, jtag probe
// assumes the map header on the include path
`include "jrdu_map.svh"
`timescale 1ns/1ps
`default_nettype none
module jtag_run_time_debug_unit_tb_top import jrdu_pkg::*;;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, perr;
    logic tck, tms, tdi, tdo, isp_sel, isp_tdo, evt_in, evt_out_n, evt_oe;
    logic core_run, core_rst, instr_done, dbg_req, dbg_ack, irq;
    logic [7:0] paddr, dbg_rdata, rv;
    logic [31:0] pwdata, prdata;
    logic [15:0] pc, a;
    logic [2:0] sp;
    logic [40:0] o;
    jrdu_acc_t acc, dbg;
    int n_errors, comparisons, n_lo, n_rst, k;
    jrdu_top jrdu_top_inst (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .ISP_SEL(isp_sel),
        .ISP_TDO(isp_tdo), .EVT_IN(evt_in), .EVT_OUT_N(evt_out_n), .EVT_OE(evt_oe),
        .CORE_RUN(core_run), .CORE_RST(core_rst), .INSTR_DONE(instr_done), .PC(pc),
        .ACC(acc), .DBG_REQ(dbg_req), .DBG(dbg), .DBG_ACK(dbg_ack),
        .DBG_RDATA(dbg_rdata), .IRQ(irq));
    jrdu_probe jrdu_probe_inst (.MCLK(mclk), .TDO(tdo), .TCK(tck), .TMS(tms), .TDI(tdi));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        isp_tdo <= 1'($urandom);
        n_lo <= n_lo + (evt_out_n === 1'b0);
        n_rst <= n_rst + (core_rst === 1'b1);
    end
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        perr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, ad, d, r);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, ad, 32'h0, r);
        chk(r, e);
    endtask
    task automatic hit(input logic w, input logic [2:0] s, input logic [15:0] ad,
                       input logic [7:0] d, input logic e);
        int n0;
        n0 = n_lo;
        @(posedge mclk);
        acc <= {1'b1, w, s, ad, d};
        @(posedge mclk);
        acc <= '0;
        repeat (5) @(posedge mclk);
        chk(32'(n_lo - n0), 32'(e));
        chk(core_run, !e);
        if (e) rd(`JRDU_A_IRQ, 32'h1);
        if (e) wr(`JRDU_A_CTRL, 32'he2);
    endtask
    initial begin
        #3000000;
        n_errors++;
        stop_test();
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, instr_done, acc, dbg_ack} = '0;
        {pc, dbg_rdata, evt_in} = '1;
        void'($urandom(64022));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rd(`JRDU_A_MASK, 32'h0);
        for (int i = 0; i < 2; i++) begin
            rd(i ? 8'h34 : 8'h02, 32'h0);
            chk(perr, 1'b1);
        end
        wr(`JRDU_A_CTRL, 32'h1);
        rd(`JRDU_A_STAT, 32'h1);
        wr(`JRDU_A_CTRL, 32'h8);
        @(posedge mclk);
        chk(core_run, 1'b1);
        instr_done <= 1'b1;
        @(posedge mclk);
        instr_done <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(core_run, 1'b0);
        wr(`JRDU_A_CTRL, 32'h4);
        repeat (3) @(posedge mclk);
        chk(n_rst, 32'h1);
        wr(`JRDU_A_CTRL, 32'he2);
        wr(`JRDU_A_MASK, 32'h7);
        chk(evt_oe, 1'b1);
        for (int i = 0; i < 4; i++) begin
            {a, rv, sp} = {16'($urandom), 8'($urandom), 3'($urandom % 5)};
            wr(8'(`JRDU_A_BP0 + 4 * i), {5'b00101, sp, rv, a});
            hit(~i[0], i[0] ? 3'((sp + 1) % 5) : sp, a, rv, 1'b0);
            hit(1'b0, sp, a, rv, 1'b1);
            wr(8'(`JRDU_A_BP0 + 4 * i), 32'h0);
        end
        wr(`JRDU_A_BP0, {5'b00101, sp, rv, a});
        wr(8'h30, {5'b00101, sp, ~rv, a});
        wr(`JRDU_A_CMB, 32'h8);
        hit(1'b0, sp, a, rv, 1'b1);
        wr(`JRDU_A_CMB, 32'h9);
        hit(1'b0, sp, a, rv, 1'b0);
        wr(8'h30, 32'h0);
        wr(`JRDU_A_RHI, 32'h20);
        for (int i = 0; i < 4; i++) begin
            wr(`JRDU_A_RLO, {1'b0, i[1], 6'b101111, 24'h10});
            hit(1'b0, 3'h2, i[0] ? 16'h30 : 16'h15, 8'h0, i[1] ^ !i[0]);
        end
        wr(`JRDU_A_RLO, 32'h0);
        for (int i = 0; i < 2; i++) begin
            {a, rv, sp} = {16'($urandom), 8'($urandom), 3'($urandom % 5)};
            wr(`JRDU_A_MCMD, {i[0], 4'h0, sp, rv, a});
            for (k = 0; k < 9 && dbg_req !== 1'b1; k++) @(posedge mclk);
            repeat ($urandom % 8) @(posedge mclk);
            chk({dbg_req, dbg}, {2'b11, i[0], sp, a, rv});
            chk(core_run, 1'b1);
            {dbg_ack, dbg_rdata} <= {1'b1, rv};
            @(posedge mclk);
            {dbg_ack, dbg_rdata} <= {1'b0, ~rv};
            repeat (2) @(posedge mclk);
            chk(irq, 1'b1);
            if (!i[0]) rd(`JRDU_A_MRD, rv);
            rd(`JRDU_A_IRQ, 32'h2);
        end
        wr(`JRDU_A_CTRL, 32'h2);
        evt_in <= 1'b0;
        repeat (4) @(posedge mclk);
        evt_in <= 1'b1;
        rd(`JRDU_A_IRQ, 32'h5);
        @(posedge mclk);
        jrdu_probe_inst.tap_reset();
        jrdu_probe_inst.scan(1'b1, 4, 41'h8, o);
        chk(o[3:0], 4'h1);
        jrdu_probe_inst.scan(1'b0, 41, {1'b1, 8'h0c, 32'h3}, o);
        rd(`JRDU_A_MASK, 32'h3);
        jrdu_probe_inst.scan(1'b1, 4, 41'h2, o);
        chk(isp_sel, 1'b1);
        jrdu_probe_inst.scan(1'b1, 4, 41'h9, o);
        wr(`JRDU_A_CTRL, 32'h12);
        pc <= 16'($urandom);
        instr_done <= 1'b1;
        @(posedge mclk);
        instr_done <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(core_run, 1'b0);
        jrdu_probe_inst.scan(1'b0, 41, 41'h0, o);
        chk(o[16:0], {1'b1, pc});
        repeat (3) @(posedge mclk);
        chk(core_run, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
